/* File: design/sbg_pkg.sv */
package sbg_pkg;

    // ------------------------------------------------------------
    // secondary side sizes and field positions
    // ------------------------------------------------------------
    localparam int          SBG_NUM_CLOCKS    = 10;        // clock fan-out outputs
    localparam int          SBG_NUM_REQ       = 9;         // internal arbiter request lines
    localparam int          SBG_CLK_DIV       = 4;         // core cycles per half clock out
    localparam int          SBG_SYNC_STAGES   = 2;         // synchroniser depth
    localparam logic [7:0]  SBG_BCR_OFFSET    = 8'h3E;     // bridge control register offset
    localparam int          SBG_BCR_SRST_BIT  = 6;         // secondary reset control bit

    // arbiter mode states
    typedef enum logic [1:0] {
        SBG_ARB_IDLE  = 2'b00,
        SBG_ARB_GRANT = 2'b01,
        SBG_ARB_EXT   = 2'b10
    } sbg_arb_e;

    // bundle of secondary arbitration terminals as seen by the block
    typedef struct packed {
        logic reqZero;     // sampled request-zero terminal
        logic extSelect;   // sampled external arbiter select
    } sbg_arbin_s;

endpackage : sbg_pkg

/* File: design/sbg_sync2.sv */
`timescale 1ns/100ps
`default_nettype none

// two-flop synchroniser; first stage feeds only the second
module sbg_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_r;   // first stage, read by the second only

    // ------------------------------------------------------------
    // two stages
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_r  <= '0;
            syncOut <= '0;
        end else begin
            meta_r  <= asyncIn;
            syncOut <= meta_r;
        end
    end
endmodule : sbg_sync2

`default_nettype wire

/* File: design/sbg_secondary_glue.sv */
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - drive one secondary clock per attached device
// - secondary clock input aligns secondary logic
// - select high disables internal secondary arbiter
// - external mode: request-zero carries external grant
// - external mode: grant-zero requests bus mastership
// - secondary reset is primary reset OR bit
// - secondary reset path is not clock-synchronised
module sbg_secondary_glue
    import sbg_pkg::*;
#(
    parameter int NUM_CLOCKS = SBG_NUM_CLOCKS,
    parameter int NUM_REQ    = SBG_NUM_REQ,
    parameter int CLK_DIV    = SBG_CLK_DIV
) (
    // core clock and reset
    input  wire logic                clk,
    input  wire logic                resetn,
    // primary reset pin and bridge control reset bit
    input  wire logic                primaryResetn,
    input  wire logic                secBusResetBit,
    // secondary clock fan-out and returned clock
    output logic [NUM_CLOCKS-1:0]    sec_clock_fanout,
    input  wire logic                secClockIn,
    // arbitration mode strap
    input  wire logic                ext_arbiter_select,
    // request-zero and grant-zero terminals
    input  wire logic                sec_request_zero,
    output logic                     sec_grant_zero,
    output logic                     secGrantZeroOe,
    // remaining internal arbiter lines
    input  wire logic [NUM_REQ-1:1]  secRequestn,
    output logic      [NUM_REQ-1:1]  secGrantn,
    // bridge master side
    input  wire logic                bridgeWantsBus,
    output logic                     bridgeOwnsBus,
    output logic                     secEdgeSeen,
    // secondary reset output, active low
    output logic                     secResetn
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam int CW = $clog2(CLK_DIV + 1);
    localparam logic [CW-1:0] DIV_LAST = CW'(CLK_DIV - 1);
    // divider width holds CLK_DIV itself; a spare bit costs one flop and keeps
    // any divide value legal without touching the terminal count

    logic [CW-1:0]          divCnt_r;         // clock divider count
    logic                   clkOut_r;         // divided clock level
    logic                   secClkSync;       // synchronised returned clock
    logic                   secClkPrev_r;     // previous sample for edge find
    logic [NUM_REQ-1:0]     reqSync;          // synchronised requests, active low
    logic                   extSelSync;       // synchronised strap
    sbg_arbin_s             arbIn;            // bundled arbitration inputs
    sbg_arb_e               state_r;          // arbiter state
    sbg_arb_e               state_nxt;
    logic [NUM_REQ-1:0]     grant_r;          // one-hot grant, active high
    logic [NUM_REQ-1:0]     grant_nxt;
    logic                   extGrant;         // grant from external arbiter

    // ------------------------------------------------------------
    // clock fan-out
    // ------------------------------------------------------------
    // free running divider; all outputs share one phase to keep skew equal
    always_ff @(posedge clk) begin
        if (!resetn) begin
            divCnt_r <= '0;
            clkOut_r <= 1'b0;
        end else if (divCnt_r == DIV_LAST) begin
            divCnt_r <= '0;
            clkOut_r <= ~clkOut_r;
        end else begin
            divCnt_r <= divCnt_r + CW'(1);
        end
    end

    // one copy per device, all driven by the single clkOut_r flop
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CLOCKS; gi++) begin : g_fan
            assign sec_clock_fanout[gi] = clkOut_r;
        end
    endgenerate
    // a gated or per-slot clock would need its own divider; all slots run
    // together here, so an unused slot still toggles

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    sbg_sync2 #(.WIDTH(NUM_REQ + 2)) u_sync (
        .clk     (clk),
        .resetn  (resetn),
        .asyncIn ({secClockIn, ext_arbiter_select, secRequestn, sec_request_zero}),
        .syncOut ({secClkSync, extSelSync, reqSync[NUM_REQ-1:1], reqSync[0]})
    );

    // after reset the stages read zero, i.e. every request asserted; harmless,
    // because no returned clock edge can be seen before real samples arrive
    assign arbIn.reqZero   = reqSync[0];
    assign arbIn.extSelect = extSelSync;

    // ------------------------------------------------------------
    // secondary clock edge detection
    // ------------------------------------------------------------
    // device grants and releases, apart from the clear on entering external mode, move only on rising edges
    // of the returned clock, so grants change where devices sample them
    always_ff @(posedge clk) begin
        if (!resetn) begin
            secClkPrev_r <= 1'b0;
        end else begin
            secClkPrev_r <= secClkSync;
        end
    end
    assign secEdgeSeen = secClkSync & ~secClkPrev_r;

    // ------------------------------------------------------------
    // arbiter
    // ------------------------------------------------------------
    // in external mode request-zero pin carries the grant, active low
    assign extGrant = ~arbIn.reqZero;

    // fixed priority pick; the bridge itself is lowest priority
    function automatic logic [NUM_REQ-1:0] pickGrant(input logic [NUM_REQ-1:0] reqn);
        logic [NUM_REQ-1:0] g;
        g = '0;
        for (int i = NUM_REQ - 1; i >= 0; i--) begin
            if (!reqn[i]) begin
                g = '0;
                g[i] = 1'b1;
            end
        end
        return g;
    endfunction : pickGrant

    // leaving external mode always passes through idle, so no grant from the
    // old mode survives the switch
    always_comb begin
        state_nxt = state_r;
        grant_nxt = grant_r;
        case (state_r)
            SBG_ARB_IDLE: begin
                if (arbIn.extSelect) begin
                    state_nxt = SBG_ARB_EXT;
                    grant_nxt = '0;
                end else if (secEdgeSeen && (reqSync != '1)) begin
                    state_nxt = SBG_ARB_GRANT;
                    grant_nxt = pickGrant(reqSync);
                end
            end
            SBG_ARB_GRANT: begin
                if (arbIn.extSelect) begin
                    state_nxt = SBG_ARB_EXT;
                    grant_nxt = '0;
                end else if (secEdgeSeen && ((grant_r & ~reqSync) == '0)) begin
                    // holder dropped its request: release and re-arbitrate
                    state_nxt = SBG_ARB_IDLE;
                    grant_nxt = '0;
                end
            end
            SBG_ARB_EXT: begin
                grant_nxt = '0;                          // internal arbiter off
                if (!arbIn.extSelect) begin
                    state_nxt = SBG_ARB_IDLE;
                end
            end
            default: begin
                state_nxt = SBG_ARB_IDLE;
                grant_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= SBG_ARB_IDLE;
            grant_r <= '0;
        end else begin
            state_r <= state_nxt;
            grant_r <= grant_nxt;
        end
    end

    // ------------------------------------------------------------
    // terminal roles
    // ------------------------------------------------------------
    // grant-zero is an output in both modes: grant or bridge request
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sec_grant_zero <= 1'b1;
            secGrantn      <= '1;
            bridgeOwnsBus  <= 1'b0;
        end else if (state_r == SBG_ARB_EXT) begin
            sec_grant_zero <= ~bridgeWantsBus;
            secGrantn      <= '1;
            bridgeOwnsBus  <= extGrant & bridgeWantsBus;
        end else begin
            sec_grant_zero <= ~grant_r[0];
            secGrantn      <= ~grant_r[NUM_REQ-1:1];
            // bridge gets the bus when nobody else requests
            bridgeOwnsBus  <= bridgeWantsBus && (state_r == SBG_ARB_IDLE)
                              && (reqSync == '1);
        end
    end
    // the pin carries our grant or our request, so it is never released
    assign secGrantZeroOe = 1'b1;

    // ------------------------------------------------------------
    // secondary reset
    // ------------------------------------------------------------
    // pure gate, no flop: follows primary reset at any moment, limitation
    // is that glitches on either input reach the pin
    // the control bit comes from a flop on clk, so only the pin side is
    // asynchronous; both are levels, never edges
    assign secResetn = primaryResetn & ~secBusResetBit;

endmodule : sbg_secondary_glue

`default_nettype wire

/* File: sim/sbg_glue_asserts.sv */
`timescale 1ns/100ps
`default_nettype none

// watches the secondary glue ports; clock high time assumes CLK_DIV of 4
module sbg_glue_asserts #(
    parameter int NUM_CLOCKS = 10,
    parameter int NUM_REQ    = 9
) (
    // core clock and reset
    input wire logic                  clk,
    input wire logic                  resetn,
    // reset sources
    input wire logic                  primaryResetn,
    input wire logic                  secBusResetBit,
    // clocks
    input wire logic [NUM_CLOCKS-1:0] sec_clock_fanout,
    input wire logic                  secClockIn,
    // arbitration and secondary reset
    input wire logic                  ext_arbiter_select,
    input wire logic                  sec_request_zero,
    input wire logic                  sec_grant_zero,
    input wire logic [NUM_REQ-1:1]    secGrantn,
    input wire logic                  bridgeWantsBus,
    input wire logic                  bridgeOwnsBus,
    input wire logic                  secEdgeSeen,
    input wire logic                  secResetn
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_reset_or: assert property (secResetn == (primaryResetn & ~secBusResetBit))
        else $error("secondary reset differs from its sources");
    a_clocks_equal: assert property (sec_clock_fanout == {NUM_CLOCKS{sec_clock_fanout[0]}})
        else $error("fan-out clocks out of phase");
    a_clock_high: assert property ($rose(sec_clock_fanout[0]) |->
        sec_clock_fanout[0][*4] ##1 !sec_clock_fanout[0]) else $error("clock high time wrong");
    a_edge_found: assert property ($rose(secClockIn) |-> ##[1:4] secEdgeSeen)
        else $error("returned clock edge missed");
    a_ext_grants_off: assert property (ext_arbiter_select[*6] |-> &secGrantn)
        else $error("internal grant in external mode");
    a_ext_request: assert property ((ext_arbiter_select && $stable(bridgeWantsBus))[*6]
        |-> sec_grant_zero == !bridgeWantsBus) else $error("grant-zero not carrying request");
    a_ext_owns: assert property ((ext_arbiter_select && !sec_request_zero && bridgeWantsBus)[*6]
        |-> bridgeOwnsBus) else $error("external grant ignored");
    a_ext_no_own: assert property ((ext_arbiter_select && sec_request_zero)[*6]
        |-> !bridgeOwnsBus) else $error("bus owned without external grant");
    a_int_release: assert property ((!ext_arbiter_select && sec_request_zero)[*8] ##1
        (!ext_arbiter_select && sec_request_zero)[*8] |-> sec_grant_zero)
        else $error("grant zero held without request");

    c_int_grant: cover property (!ext_arbiter_select && !sec_grant_zero);
    c_ext_owned: cover property (ext_arbiter_select && bridgeOwnsBus);
    c_soft_reset: cover property (primaryResetn && !secResetn);
endmodule : sbg_glue_asserts

`default_nettype wire

/* File: sim/sbg_far_model.sv */
`timescale 1ns/100ps
`default_nettype none

// device zero and the optional external arbiter on the secondary bus
module sbg_far_model (
    // clocks
    input  wire logic [9:0] sec_clock_fanout,
    output logic            secClockIn,
    // arbitration
    input  wire logic       ext_arbiter_select,
    input  wire logic       sec_grant_zero,
    input  wire logic       devReqn,
    output logic            sec_request_zero
);
    // returned clock runs free, phase unrelated to the core clock
    initial begin
        secClockIn = 1'b0;
        #13;
        forever #40 secClockIn = ~secClockIn;
    end
    // both parties act only on the rise of fan-out clock zero, sec_clock_fanout[0]
    initial sec_request_zero = 1'b1;
    always @(posedge sec_clock_fanout[0]) begin
        sec_request_zero <= ext_arbiter_select ? sec_grant_zero : devReqn;
    end
endmodule : sbg_far_model

`default_nettype wire

/* File: sim/sbg_secondary_glue_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module sbg_secondary_glue_bench;
    import sbg_pkg::*;
    logic       clk = 0, resetn = 0, primaryResetn = 1, secBusResetBit = 0;
    logic       ext_arbiter_select = 0, bridgeWantsBus = 0, devReqn = 1;
    logic [8:1] secRequestn = '1;
    logic [9:0] sec_clock_fanout;
    logic [8:1] secGrantn;
    logic       secClockIn, sec_request_zero, sec_grant_zero, secGrantZeroOe;
    logic       bridgeOwnsBus, secEdgeSeen, secResetn, got;
    logic [1:0] k;
    int         n_mismatch = 0, checks = 0, cyc = 0;
    typedef struct { int sel; logic exp; } sbg_note_s;
    sbg_note_s  q[$];
    sbg_note_s  n;
    string      nm[6] = '{"secResetn", "sec_grant_zero", "bridgeOwnsBus", "grant1", "grantsOff",
                          "secGrantZeroOe"};

    always #5 clk = ~clk;

    sbg_secondary_glue i_dut (.clk, .resetn, .primaryResetn, .secBusResetBit, .sec_clock_fanout,
        .secClockIn, .ext_arbiter_select, .sec_request_zero, .sec_grant_zero, .secGrantZeroOe,
        .secRequestn, .secGrantn, .bridgeWantsBus, .bridgeOwnsBus, .secEdgeSeen, .secResetn);
    sbg_far_model i_far (.sec_clock_fanout, .secClockIn, .ext_arbiter_select, .sec_grant_zero,
        .devReqn, .sec_request_zero);

    task note(input int s, input logic e);
        q.push_back('{s, e});
    endtask : note

    task step(input int c);
        repeat (c) @(posedge clk);
    endtask : step

    task end_sim();
        if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    // monitor: compares settled outputs with the oldest notes
    always @(negedge clk) while (q.size() > 0) begin
        n = q.pop_front();
        got = n.sel == 0 ? secResetn : n.sel == 1 ? sec_grant_zero : n.sel == 2 ? bridgeOwnsBus :
            n.sel == 3 ? secGrantn[1] : n.sel == 4 ? &secGrantn : secGrantZeroOe;
        checks++;
        if (got !== n.exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", nm[n.sel], n.exp, got);
        end
    end

    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) if (++cyc == 3000) begin
        n_mismatch++;
        end_sim();
    end

    initial begin
        void'($urandom(32'h15E04CD9));
        step(16);
        resetn <= 1'b1;
        // reset sources in random order; output must follow within half a cycle
        for (int i = 0; i < 8; i++) begin
            k = 2'($urandom);
            primaryResetn  <= k[0];
            secBusResetBit <= k[1];
            note(0, k[0] & ~k[1]);
            step(1);
        end
        primaryResetn  <= 1'b1;
        secBusResetBit <= 1'b0;
        // internal mode: request zero beats request one, then hands over
        secRequestn <= {7'($urandom), 1'b0};
        devReqn     <= 1'b0;
        step(32);
        note(1, 1'b0);
        note(3, 1'b1);
        devReqn <= 1'b1;
        step(32);
        note(1, 1'b1);
        note(3, 1'b0);
        // external mode: requests ignored, grant-zero requests, grant input owns
        ext_arbiter_select <= 1'b1;
        secRequestn        <= 8'($urandom);
        bridgeWantsBus     <= 1'b1;
        step(40);
        note(4, 1'b1);
        note(1, 1'b0);
        note(2, 1'b1);
        note(5, 1'b1);
        bridgeWantsBus <= 1'b0;
        step(40);
        note(1, 1'b1);
        note(2, 1'b0);
        // core reset leaves the secondary reset alone
        resetn <= 1'b0;
        step(2);
        note(0, 1'b1);
        resetn <= 1'b1;
        step(2);
        // back to internal mode: only request zero asks, so it must win the bus
        ext_arbiter_select <= 1'b0;
        secRequestn        <= '1;
        devReqn            <= 1'b0;
        step(32);
        note(1, 1'b0);
        note(4, 1'b1);
        note(5, 1'b1);
        step(2);
        end_sim();
    end
endmodule : sbg_secondary_glue_bench

bind sbg_secondary_glue sbg_glue_asserts #(.NUM_CLOCKS(NUM_CLOCKS), .NUM_REQ(NUM_REQ)) i_chk (
    .clk, .resetn, .primaryResetn, .secBusResetBit, .sec_clock_fanout, .secClockIn,
    .ext_arbiter_select, .sec_request_zero, .sec_grant_zero, .secGrantn, .bridgeWantsBus,
    .bridgeOwnsBus, .secEdgeSeen, .secResetn);

`default_nettype wire
